/* design/eic_cfg.svh */
// register offsets, field positions and constants for the encoder index block
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH
`define EIC_OFS_CONFIG    8'h38
`define EIC_OFS_COUNT     8'h39
`define EIC_OFS_CONST     8'h3A
`define EIC_OFS_STATUS    8'h3B
`define EIC_OFS_LATCH     8'h3C
`define EIC_OFS_RAMPLATCH 8'h3E
`define EIC_BIT_DECIMAL   10
`define EIC_BIT_LATCH_X   9
`define EIC_BIT_CLR_ENC   8
`define EIC_BIT_NEG_EDGE  7
`define EIC_BIT_POS_EDGE  6
`define EIC_BIT_ONCE      5
`define EIC_BIT_CONT      4
`define EIC_BIT_SKIP_AB   3
`define EIC_BIT_POL_N     2
`define EIC_BIT_POL_B     1
`define EIC_BIT_POL_A     0
`define EIC_CONFIG_RESET  11'h000
`define EIC_CONST_RESET   32'h0001_0000
`define EIC_DIV_BINARY    17'h1_0000
`define EIC_DIV_DECIMAL   17'h0_2710
`endif

/* design/eic_pkg.sv */
// types for the encoder index block
package eic_pkg;
  typedef enum logic [1:0]
  {
    EIC_SENS_LEVEL = 2'b00,
    EIC_SENS_POS   = 2'b01,
    EIC_SENS_NEG   = 2'b10,
    EIC_SENS_BOTH  = 2'b11
  } eic_sens_t;
endpackage

/* design/eic_input_sync.sv */
// two-stage synchroniser with a previous-sample register for the encoder inputs
`timescale 1ns/1ps
module eic_input_sync
  import eic_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised level and previous sample
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] level_prev
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_next;

  always_comb
  begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level      = sync_reg;
  assign level_prev = prev_reg;
endmodule

/* design/eic_index_top.sv */
// encoder counter with index event qualification, latching and clearing
// Function
// - With the decimal bit clear, the fraction of the constant accumulates modulo 65536.
// - With the decimal bit set, the fraction of the constant accumulates modulo 10000.
// - With the ramp latch bit set, each qualifying index event also captures the ramp position.
// - With the clear bit at 0, an index event copies the count into the latch only.
// - With the clear bit at 1, an index event latches the count and zeroes the counter.
// - Edge selects at 00 make the event present while the qualified index stays active.
// - Positive select fires on going active, negative on going inactive, both on either.
// - The one-shot bit acts only on the first index event after the configuration write.
// - The continuous bit acts on every index event.
// - With quadrature qualify on, the index, A and B inputs must all match their polarities.
// - With quadrature qualify skipped, only the index polarity qualifies the event.
// - The index polarity bit selects low active at 0 and high active at 1.
// - Bit 1 gives the required B level and bit 0 the required A level.
// - A read-only register holds the count captured at the last latching index event.
// - The index status flag sets on an event, drives the event output, and clears on write one.
`timescale 1ns/1ps
`include "eic_cfg.svh"
module eic_index_top
  import eic_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // encoder pins
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        ENC_N,
  // ramp generator
  input  wire logic [31:0] RAMP_ACTUAL_POSITION,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // status
  output logic             INDEX_EVENT_FLAG,
  output logic [31:0]      ENCODER_COUNT
);
  logic [2:0]  lvl;
  logic [2:0]  lvl_prev;
  logic [10:0] cfg_reg;
  logic [10:0] cfg_next;
  logic [31:0] const_reg;
  logic [31:0] const_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [16:0] frac_reg;
  logic [16:0] frac_next;
  logic [31:0] latch_reg;
  logic [31:0] latch_next;
  logic [31:0] ramp_latch_reg;
  logic [31:0] ramp_latch_next;
  logic        armed_reg;
  logic        armed_next;
  logic        flag_reg;
  logic        flag_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        qual_now;
  logic        qual_prev;
  logic        index_event;
  logic        act;
  logic        step_up;
  logic        step_dn;
  logic [16:0] div;
  logic [17:0] frac_sum;
  logic [31:0] int_add;
  eic_sens_t   sens;

  eic_input_sync #(.WIDTH(3)) u_sync
  (
    .clk        (CLK),
    .rst        (RST),
    .pin_in     ({ENC_N, ENC_B, ENC_A}),
    .level      (lvl),
    .level_prev (lvl_prev)
  );

  // index qualification for one sample of {n,b,a}
  function automatic logic qualify(input logic [2:0] s, input logic [10:0] c);
    logic n_ok;
    logic ab_ok;
    n_ok  = (s[2] == c[`EIC_BIT_POL_N]);
    ab_ok = (s[1] == c[`EIC_BIT_POL_B]) && (s[0] == c[`EIC_BIT_POL_A]);
    return n_ok && (c[`EIC_BIT_SKIP_AB] || ab_ok);
  endfunction

  // quadrature direction from previous and current sample
  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (lvl[1:0] != lvl_prev[1:0])
    begin
      if ((lvl_prev[0] ^ lvl[1]) == 1'b1)
        step_up = 1'b1;
      else
        step_dn = 1'b1;
    end
  end

  always_comb
  begin
    qual_now  = qualify(lvl, cfg_reg);
    qual_prev = qualify(lvl_prev, cfg_reg);
    sens      = eic_sens_t'({cfg_reg[`EIC_BIT_NEG_EDGE], cfg_reg[`EIC_BIT_POS_EDGE]});
    case (sens)
      EIC_SENS_LEVEL: index_event = qual_now;
      EIC_SENS_POS:   index_event = qual_now && !qual_prev;
      EIC_SENS_NEG:   index_event = !qual_now && qual_prev;
      EIC_SENS_BOTH:  index_event = qual_now != qual_prev;
      default:        index_event = 1'b0;
    endcase
    act = index_event && (cfg_reg[`EIC_BIT_CONT] || (cfg_reg[`EIC_BIT_ONCE] && armed_reg));
  end

  // fractional accumulator
  always_comb
  begin
    div     = cfg_reg[`EIC_BIT_DECIMAL] ? `EIC_DIV_DECIMAL : `EIC_DIV_BINARY;
    int_add = {{16{const_reg[31]}}, const_reg[31:16]};
    frac_sum  = {1'b0, frac_reg};
    frac_next = frac_reg;
    count_next = count_reg;
    if (step_up)
    begin
      frac_sum = {1'b0, frac_reg} + {2'b00, const_reg[15:0]};
      if (frac_sum >= {1'b0, div})
      begin
        frac_next  = 17'(frac_sum - {1'b0, div});
        count_next = count_reg + int_add + 32'h0000_0001;
      end
      else
      begin
        frac_next  = frac_sum[16:0];
        count_next = count_reg + int_add;
      end
    end
    else if (step_dn)
    begin
      if (frac_reg >= {1'b0, const_reg[15:0]})
      begin
        frac_next  = 17'(frac_reg - {1'b0, const_reg[15:0]});
        count_next = count_reg - int_add;
      end
      else
      begin
        frac_next  = 17'(frac_reg + div - {1'b0, const_reg[15:0]});
        count_next = count_reg - int_add - 32'h0000_0001;
      end
    end
    if (WR && ADDR == `EIC_OFS_COUNT)
      count_next = WDATA;
    if (act && cfg_reg[`EIC_BIT_CLR_ENC])
    begin
      count_next = 32'h0000_0000;
      frac_next  = 17'h0_0000;
    end
  end

  // registers, latches and status
  always_comb
  begin
    cfg_next        = cfg_reg;
    const_next      = const_reg;
    latch_next      = latch_reg;
    ramp_latch_next = ramp_latch_reg;
    armed_next      = armed_reg;
    flag_next       = flag_reg;
    rdata_next      = 32'h0000_0000;
    if (act)
    begin
      latch_next = count_reg;
      armed_next = 1'b0;
      if (cfg_reg[`EIC_BIT_LATCH_X])
        ramp_latch_next = RAMP_ACTUAL_POSITION;
    end
    if (WR && ADDR == `EIC_OFS_CONFIG)
    begin
      cfg_next   = WDATA[10:0];
      armed_next = 1'b1;
    end
    if (WR && ADDR == `EIC_OFS_CONST)
      const_next = WDATA;
    if (WR && ADDR == `EIC_OFS_STATUS && WDATA[0])
      flag_next = 1'b0;
    if (index_event)
      flag_next = 1'b1;
    if (RD)
    begin
      case (ADDR)
        `EIC_OFS_CONFIG:    rdata_next = {21'h00_0000, cfg_reg};
        `EIC_OFS_COUNT:     rdata_next = count_reg;
        `EIC_OFS_STATUS:    rdata_next = {31'h0000_0000, flag_reg};
        `EIC_OFS_LATCH:     rdata_next = latch_reg;
        `EIC_OFS_RAMPLATCH: rdata_next = ramp_latch_reg;
        default:            rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_reg        <= `EIC_CONFIG_RESET;
      const_reg      <= `EIC_CONST_RESET;
      count_reg      <= 32'h0000_0000;
      frac_reg       <= 17'h0_0000;
      latch_reg      <= 32'h0000_0000;
      ramp_latch_reg <= 32'h0000_0000;
      armed_reg      <= 1'b0;
      flag_reg       <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
    end
    else
    begin
      cfg_reg        <= cfg_next;
      const_reg      <= const_next;
      count_reg      <= count_next;
      frac_reg       <= frac_next;
      latch_reg      <= latch_next;
      ramp_latch_reg <= ramp_latch_next;
      armed_reg      <= armed_next;
      flag_reg       <= flag_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign RDATA            = rdata_reg;
  assign INDEX_EVENT_FLAG = flag_reg;
  assign ENCODER_COUNT    = count_reg;

  a_latch_copy: assert property (@(posedge CLK) disable iff (RST)
    act |=> latch_reg == $past(count_reg))
    else $error("latch did not capture count");
  a_clear_count: assert property (@(posedge CLK) disable iff (RST)
    act && cfg_reg[`EIC_BIT_CLR_ENC] |=> count_reg == 32'h0000_0000)
    else $error("count not cleared on index");
  a_ramp_latch: assert property (@(posedge CLK) disable iff (RST)
    act && cfg_reg[`EIC_BIT_LATCH_X] |=> ramp_latch_reg == $past(RAMP_ACTUAL_POSITION))
    else $error("ramp position not latched");
  a_level_sense: assert property (@(posedge CLK) disable iff (RST)
    sens == EIC_SENS_LEVEL && cfg_reg[`EIC_BIT_SKIP_AB]
      |-> index_event == (lvl[2] == cfg_reg[`EIC_BIT_POL_N]))
    else $error("level event mismatch");
  a_pos_edge: assert property (@(posedge CLK) disable iff (RST)
    sens == EIC_SENS_POS && cfg_reg[`EIC_BIT_SKIP_AB] && index_event
      |-> lvl[2] == cfg_reg[`EIC_BIT_POL_N] && lvl_prev[2] != cfg_reg[`EIC_BIT_POL_N])
    else $error("positive edge event without rise");
  a_once_only: assert property (@(posedge CLK) disable iff (RST)
    act && !cfg_reg[`EIC_BIT_CONT] ##1 !(WR && ADDR == `EIC_OFS_CONFIG) |-> !act)
    else $error("one-shot acted twice");
  a_qualify_ab: assert property (@(posedge CLK) disable iff (RST)
    !cfg_reg[`EIC_BIT_SKIP_AB] && qual_now |-> lvl[1] == cfg_reg[`EIC_BIT_POL_B]
      && lvl[0] == cfg_reg[`EIC_BIT_POL_A])
    else $error("index qualified with wrong quadrature levels");
  a_pol_n: assert property (@(posedge CLK) disable iff (RST)
    qual_now |-> lvl[2] == cfg_reg[`EIC_BIT_POL_N])
    else $error("index qualified at wrong polarity");
  a_flag_set: assert property (@(posedge CLK) disable iff (RST)
    index_event |=> INDEX_EVENT_FLAG)
    else $error("event flag not set");
  a_flag_hold: assert property (@(posedge CLK) disable iff (RST)
    flag_reg && !(WR && ADDR == `EIC_OFS_STATUS && WDATA[0]) |=> flag_reg)
    else $error("event flag dropped without clear");

  // edge, qualification, latch, status and count checks
  a_neg_edge: assert property (@(posedge CLK) disable iff (RST)
    sens == EIC_SENS_NEG && cfg_reg[`EIC_BIT_SKIP_AB] && index_event
      |-> lvl[2] != cfg_reg[`EIC_BIT_POL_N] && lvl_prev[2] == cfg_reg[`EIC_BIT_POL_N])
    else $error("negative edge event without fall");
  a_both_edge: assert property (@(posedge CLK) disable iff (RST)
    sens == EIC_SENS_BOTH && cfg_reg[`EIC_BIT_SKIP_AB]
      |-> index_event == (lvl[2] != lvl_prev[2]))
    else $error("either edge event mismatch");
  a_skip_ab: assert property (@(posedge CLK) disable iff (RST)
    cfg_reg[`EIC_BIT_SKIP_AB] |-> qual_now == (lvl[2] == cfg_reg[`EIC_BIT_POL_N]))
    else $error("quadrature levels affected skipped qualification");
  a_count_keep: assert property (@(posedge CLK) disable iff (RST)
    act && !cfg_reg[`EIC_BIT_CLR_ENC] && !step_up && !step_dn
      && !(WR && ADDR == `EIC_OFS_COUNT) |=> count_reg == $past(count_reg))
    else $error("count changed by latch-only event");
  a_once_disarm: assert property (@(posedge CLK) disable iff (RST)
    act && !(WR && ADDR == `EIC_OFS_CONFIG) |=> !armed_reg)
    else $error("one-shot still armed after event");
  a_latch_read: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == `EIC_OFS_LATCH |=> RDATA == $past(latch_reg))
    else $error("latch read data mismatch");
  a_flag_clear: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == `EIC_OFS_STATUS && WDATA[0] && !index_event
      |=> !INDEX_EVENT_FLAG)
    else $error("event flag not cleared by write one");
  a_unit_step: assert property (@(posedge CLK) disable iff (RST)
    step_up && const_reg == `EIC_CONST_RESET && !cfg_reg[`EIC_BIT_DECIMAL]
      && !(WR && ADDR == `EIC_OFS_COUNT) && !(act && cfg_reg[`EIC_BIT_CLR_ENC])
      |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("unit constant step did not add one");
  a_edge_sample: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> lvl_prev == $past(lvl))
    else $error("previous sample does not follow synchronised level");
endmodule

/* testbench/eic_encoder_model.sv */
// quadrature encoder model with index channel
`timescale 1ns/1ps
module eic_encoder_model
(
  // clock
  input  wire logic clk,
  // encoder outputs
  output logic      enc_a,
  output logic      enc_b,
  output logic      enc_n
);
  initial
  begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
  end
  // one gray-code step forward, one line at a time
  task automatic step();
    @(posedge clk);
    if (enc_a == enc_b)
      enc_b <= ~enc_b;
    else
      enc_a <= ~enc_a;
    repeat (5) @(posedge clk);
  endtask
  // one gray-code step backward
  task automatic step_back();
    @(posedge clk);
    if (enc_a == enc_b)
      enc_a <= ~enc_a;
    else
      enc_b <= ~enc_b;
    repeat (5) @(posedge clk);
  endtask
  // index level change, then settle
  task automatic set_n(input logic v);
    @(posedge clk);
    enc_n <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* testbench/eic_index_top_tb.sv */
// self-checking testbench for the encoder index block
`timescale 1ns/1ps
`include "eic_cfg.svh"
module eic_index_top_tb;
  logic        clk;
  logic        rst;
  logic        enc_a;
  logic        enc_b;
  logic        enc_n;
  logic [31:0] ramp_pos;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        flag;
  logic [31:0] count;
  int          fail_count;
  int          n_tests;

  eic_encoder_model i_enc
  (
    .clk   (clk),
    .enc_a (enc_a),
    .enc_b (enc_b),
    .enc_n (enc_n)
  );

  eic_index_top i_dut
  (
    .CLK                  (clk),
    .RST                  (rst),
    .ENC_A                (enc_a),
    .ENC_B                (enc_b),
    .ENC_N                (enc_n),
    .RAMP_ACTUAL_POSITION (ramp_pos),
    .ADDR                 (addr),
    .WDATA                (wdata),
    .WR                   (wr),
    .RD                   (rd),
    .RDATA                (rdata),
    .INDEX_EVENT_FLAG     (flag),
    .ENCODER_COUNT        (count)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  // flag after index going high, then after going low
  task automatic edge_row(input logic [10:0] cfg, input logic f_rise, input logic f_fall);
    wr_reg(`EIC_OFS_CONFIG, {21'h0, cfg});
    repeat (3) @(posedge clk);
    wr_reg(`EIC_OFS_STATUS, 32'h0000_0001);
    i_enc.set_n(1'b1);
    chk("flag_rise", {31'h0, flag}, {31'h0, f_rise});
    wr_reg(`EIC_OFS_STATUS, 32'h0000_0001);
    i_enc.set_n(1'b0);
    chk("flag_fall", {31'h0, flag}, {31'h0, f_fall});
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial
  begin
    rst        = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    ramp_pos   = 32'h0000_ABCD;
    fail_count = 0;
    n_tests    = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // register map
    rd_chk("config_reset", `EIC_OFS_CONFIG, 32'h0);
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 32'h0);
    rd_chk("const_readback", `EIC_OFS_CONST, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    rd_chk("latch_reset", `EIC_OFS_LATCH, 32'h0);
    wr_reg(8'h40, 32'hFFFF_FFFF);
    wr_reg(`EIC_OFS_CONFIG, 32'hFFFF_FFFF);
    rd_chk("config_width", `EIC_OFS_CONFIG, 32'h0000_07FF);
    wr_reg(`EIC_OFS_CONFIG, 32'h0);
    // counting and prescaler
    repeat (4) i_enc.step();
    chk("count_unit", count, 32'h4);
    wr_reg(`EIC_OFS_CONST, 32'h0000_8000);
    wr_reg(`EIC_OFS_COUNT, 32'h0);
    repeat (4) i_enc.step();
    chk("count_binary", count, 32'h2);
    wr_reg(`EIC_OFS_CONFIG, 32'h0000_0400);
    wr_reg(`EIC_OFS_CONST, 32'h0000_1388);
    wr_reg(`EIC_OFS_COUNT, 32'h0);
    repeat (4) i_enc.step();
    chk("count_decimal", count, 32'h2);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0010);
    repeat (4) i_enc.step_back();
    chk("count_down", count, 32'h0000_000E);
    // latch only
    wr_reg(`EIC_OFS_CONFIG, 32'h0000_025C);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0123);
    i_enc.set_n(1'b1);
    i_enc.set_n(1'b0);
    rd_chk("latch_keep", `EIC_OFS_LATCH, 32'h0000_0123);
    rd_chk("ramp_latch", `EIC_OFS_RAMPLATCH, 32'h0000_ABCD);
    rd_chk("count_kept", `EIC_OFS_COUNT, 32'h0000_0123);
    chk("flag_set", {31'h0, flag}, 32'h1);
    rd_chk("status_read", `EIC_OFS_STATUS, 32'h0000_0001);
    wr_reg(`EIC_OFS_STATUS, 32'h0000_0001);
    @(posedge clk);
    chk("flag_clear", {31'h0, flag}, 32'h0);
    // latch and clear, continuous
    wr_reg(`EIC_OFS_CONFIG, 32'h0000_035C);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0456);
    ramp_pos <= 32'h0000_5A5A;
    i_enc.set_n(1'b1);
    chk("count_cleared", count, 32'h0);
    rd_chk("latch_clr", `EIC_OFS_LATCH, 32'h0000_0456);
    i_enc.set_n(1'b0);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0789);
    i_enc.set_n(1'b1);
    i_enc.set_n(1'b0);
    rd_chk("latch_cont", `EIC_OFS_LATCH, 32'h0000_0789);
    // one shot without ramp capture
    wr_reg(`EIC_OFS_CONFIG, 32'h0000_006C);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0005);
    ramp_pos <= 32'h0000_2222;
    i_enc.set_n(1'b1);
    i_enc.set_n(1'b0);
    wr_reg(`EIC_OFS_COUNT, 32'h0000_0007);
    i_enc.set_n(1'b1);
    i_enc.set_n(1'b0);
    rd_chk("latch_once", `EIC_OFS_LATCH, 32'h0000_0005);
    rd_chk("ramp_hold", `EIC_OFS_RAMPLATCH, 32'h0000_5A5A);
    // sensitivity and qualification table
    edge_row(11'h04C, 1'b1, 1'b0);
    edge_row(11'h08C, 1'b0, 1'b1);
    edge_row(11'h0CC, 1'b1, 1'b1);
    edge_row(11'h00C, 1'b1, 1'b1);
    edge_row(11'h048, 1'b0, 1'b1);
    edge_row(11'h04F, 1'b1, 1'b0);
    edge_row(11'h044, 1'b1, 1'b0);
    edge_row(11'h045, 1'b0, 1'b0);
    edge_row(11'h046, 1'b0, 1'b0);
    stop_test();
  end
endmodule
